// >>> die_link_cfg.svh
// Offsets, field positions, reset values and frame counts of the link block
`ifndef DIE_LINK_CFG_SVH
`define DIE_LINK_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL_0 8'h00
`define OFS_STATUS_0 8'h04
`define OFS_STATUS_1 8'h08
`define OFS_COMMAND 8'h0c
`define OFS_WDATA 8'h10
`define OFS_RDATA 8'h14
`define OFS_ADDR_BUF 8'h18

// ----------------------------------------------------------------
// Control 0 fields
// ----------------------------------------------------------------
`define CTL_ENABLE 0
`define CTL_STOP_IN_WAIT 1
`define CTL_IRQ_ENABLE 2
`define CTL_WIDE 3
`define CTL_DIV_LSB 4
`define CTL_DIV_MSB 7
`define CTL_TMO_LSB 8
`define CTL_TMO_MSB 15
`define CTL_RESET 16'h0000

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define ST0_TIMEOUT 0
`define ST0_TARGET_ERR 1
`define ST0_CANCEL 2
`define ST0_ERROR 7
`define ST1_BUSY 0
`define ST1_TARGET_IRQ 7

// ----------------------------------------------------------------
// Command register fields and link frame
// ----------------------------------------------------------------
`define CMD_WRITE_BIT 8
`define CMD_WIDE_BIT 9
`define CODE_IDLE 2'b00
`define CODE_READ 2'b01
`define CODE_WRITE 2'b10
`define FRAME_LAST 5'd26
`define RECV_LAST 5'd15

`endif

// >>> die_link_initiator.sv
// Die link initiator: registers, transfer engine, low power, interrupts
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "die_link_cfg.svh"

module die_link_initiator
    import die_link_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic cpu_wait,
    input wire logic cpu_stop,
    output logic link_clock_out,
    output logic link_data_o,
    output logic link_data_oe_n,
    input wire logic link_data_i,
    input wire logic target_irq_in,
    output logic link_gpio_sel,
    output logic core_clock_on,
    output logic target_irq_signal,
    output logic link_error_irq
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [15:0] ctl_q;
    logic [7:0] stat0_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic [9:0] addr_buf_q;
    logic [26:0] shift_q;
    logic [4:0] bit_q;
    logic [7:0] tmo_q;
    logic is_read_q;
    logic is_idle_q;
    xfer_state_t state_q, state_d;
    logic dp_valid_q, dp_write_q, rd_loaded_q;
    logic [7:0] dp_addr_q;
    logic [31:0] hrdata_q;
    logic [1:0] sync_out;
    logic data_s, irq_s;
    logic rise_pulse, fall_pulse;
    logic link_enable, stop_in_wait, link_irq_enable;
    logic [3:0] div;
    logic [7:0] tmo_limit;
    logic error_summary_flag;
    logic idle, stop_req, park, run;
    logic addr_take, stall, dp_done;
    logic wr_ctl, wr_st0, wr_cmd, wr_wdata;
    logic start, start_real, start_idle;
    logic ack_seen, ack_timeout, stat_err, send_done, recv_done;
    logic [31:0] read_mux;

    // ----------------------------------------------------------------
    // Input synchronisers and clock divider
    // ----------------------------------------------------------------
    link_sync2 u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({target_irq_in, link_data_i}),
        .sync_out(sync_out)
    );
    assign data_s = sync_out[0];
    assign irq_s = sync_out[1];

    link_clock_gen u_clk (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .div(div),
        .link_clock_out(link_clock_out),
        .rise_pulse(rise_pulse),
        .fall_pulse(fall_pulse)
    );

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    assign link_enable = ctl_q[`CTL_ENABLE];
    assign stop_in_wait = ctl_q[`CTL_STOP_IN_WAIT];
    assign link_irq_enable = ctl_q[`CTL_IRQ_ENABLE];
    assign div = ctl_q[`CTL_DIV_MSB:`CTL_DIV_LSB];
    assign tmo_limit = ctl_q[`CTL_TMO_MSB:`CTL_TMO_LSB];
    assign error_summary_flag = stat0_q[`ST0_ERROR];

    // ----------------------------------------------------------------
    // Low-power control
    // ----------------------------------------------------------------
    assign idle = (state_q == ST_IDLE);
    // Wait with stop-in-wait clear is ignored entirely
    assign stop_req = cpu_stop | (cpu_wait & stop_in_wait);
    // Halting waits for the engine, so a pending transfer completes
    assign park = stop_req & idle;
    assign run = link_enable & ~park;
    assign core_clock_on = link_enable & ~(park & ~link_clock_out);
    assign link_gpio_sel = ~link_enable;

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    // Synchronised level is not gated by the low-power state: it wakes the CPU
    assign target_irq_signal = irq_s & link_irq_enable;
    // Error line deliberately bypasses the interrupt enable
    assign link_error_irq = error_summary_flag;

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    assign addr_take = hsel & hready & htrans[1];
    // Transfer window accesses hold the bus while the engine is busy
    assign stall = dp_valid_q & ~idle &
        ((dp_write_q & dp_addr_q == `OFS_COMMAND) |
         (~dp_write_q & dp_addr_q == `OFS_RDATA));
    assign hreadyout = ~dp_valid_q | (dp_write_q ? ~stall : rd_loaded_q);
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign dp_done = dp_valid_q & hreadyout;

    assign wr_ctl = dp_valid_q & dp_write_q & (dp_addr_q == `OFS_CONTROL_0);
    assign wr_st0 = dp_valid_q & dp_write_q & (dp_addr_q == `OFS_STATUS_0);
    assign wr_cmd = dp_done & dp_write_q & (dp_addr_q == `OFS_COMMAND);
    assign wr_wdata = dp_valid_q & dp_write_q & (dp_addr_q == `OFS_WDATA);

    assign read_mux =
        (dp_addr_q == `OFS_CONTROL_0) ? {16'h0000, ctl_q} :
        (dp_addr_q == `OFS_STATUS_0) ? {24'h000000, stat0_q} :
        (dp_addr_q == `OFS_STATUS_1) ?
            {24'h000000, irq_s, 6'h00, ~idle} :
        (dp_addr_q == `OFS_WDATA) ? {16'h0000, wdata_q} :
        (dp_addr_q == `OFS_RDATA) ? {16'h0000, rdata_q} :
        (dp_addr_q == `OFS_ADDR_BUF) ? {22'h000000, addr_buf_q} :
        32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q <= 8'h00;
        end else if (hready) begin
            dp_valid_q <= addr_take;
            dp_write_q <= hwrite;
            dp_addr_q <= {haddr[7:2], 2'b00};
        end
    end

    // Reads take one wait state so that read data leave a flip-flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_loaded_q <= 1'b0;
            hrdata_q <= 32'h00000000;
        end else if (dp_done) begin
            rd_loaded_q <= 1'b0;
        end else if (dp_valid_q & ~dp_write_q & ~stall) begin
            rd_loaded_q <= 1'b1;
            hrdata_q <= read_mux;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_q <= `CTL_RESET;
        end else if (wr_ctl) begin
            ctl_q[15:1] <= hwdata[15:1];
            // Enable is write-once: software can set it, never clear it
            ctl_q[`CTL_ENABLE] <= ctl_q[`CTL_ENABLE] | hwdata[`CTL_ENABLE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdata_q <= 16'h0000;
        end else if (wr_wdata) begin
            wdata_q <= hwdata[15:0];
        end
    end

    // Error flags: a new cause in the clearing cycle wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat0_q <= 8'h00;
        end else begin
            if (wr_st0 & hwdata[`ST0_ERROR]) begin
                stat0_q <= 8'h00;
            end
            if (ack_timeout) begin
                stat0_q[`ST0_ERROR] <= 1'b1;
                stat0_q[`ST0_TIMEOUT] <= 1'b1;
            end
            if (stat_err) begin
                stat0_q[`ST0_ERROR] <= 1'b1;
                stat0_q[`ST0_TARGET_ERR] <= 1'b1;
            end
            if (start_idle) begin
                stat0_q[`ST0_CANCEL] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Transfer engine
    // ----------------------------------------------------------------
    assign start = wr_cmd & link_enable;
    assign start_real = start & ~error_summary_flag;
    assign start_idle = start & error_summary_flag;
    assign send_done = (state_q == ST_SEND) & rise_pulse &
        (bit_q == `FRAME_LAST);
    assign ack_seen = (state_q == ST_ACK) & rise_pulse & data_s;
    assign ack_timeout = (state_q == ST_ACK) & rise_pulse & ~data_s &
        (tmo_q == tmo_limit);
    assign stat_err = (state_q == ST_STAT) & rise_pulse & data_s;
    assign recv_done = (state_q == ST_RECV) & rise_pulse &
        (bit_q == `RECV_LAST);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_SEND;
                end
            end
            ST_SEND: begin
                if (send_done) begin
                    // An idle command expects no answer
                    state_d = is_idle_q ? ST_IDLE : ST_ACK;
                end
            end
            ST_ACK: begin
                if (ack_seen) begin
                    state_d = ST_STAT;
                end else if (ack_timeout) begin
                    state_d = ST_IDLE;
                end
            end
            ST_STAT: begin
                if (rise_pulse) begin
                    state_d = (is_read_q & ~data_s) ? ST_RECV : ST_IDLE;
                end
            end
            ST_RECV: begin
                if (recv_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Frame: code(2) wide(1) address(8) data(16), most significant first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_q <= 27'h0000000;
            is_read_q <= 1'b0;
            is_idle_q <= 1'b0;
        end else if (start_real) begin
            shift_q <= {hwdata[`CMD_WRITE_BIT] ? `CODE_WRITE : `CODE_READ,
                ctl_q[`CTL_WIDE], hwdata[7:0],
                hwdata[`CMD_WRITE_BIT] ? wdata_q : 16'h0000};
            is_read_q <= ~hwdata[`CMD_WRITE_BIT];
            is_idle_q <= 1'b0;
        end else if (start_idle) begin
            shift_q <= {`CODE_IDLE, 25'h0000000};
            is_read_q <= 1'b0;
            is_idle_q <= 1'b1;
        end else if ((state_q == ST_SEND) & fall_pulse &
            (bit_q != 5'h00)) begin
            // A fall before the first rise would drop the leading bit
            shift_q <= {shift_q[25:0], 1'b0};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_q <= 5'h00;
            tmo_q <= 8'h00;
        end else if (start | send_done | (state_q == ST_STAT)) begin
            bit_q <= 5'h00;
            tmo_q <= 8'h00;
        end else if (rise_pulse) begin
            bit_q <= bit_q + 5'h01;
            tmo_q <= tmo_q + 8'h01;
        end
    end

    // Buffers stay frozen while the error flag is up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_buf_q <= 10'h000;
            rdata_q <= 16'h0000;
        end else if (start_real) begin
            addr_buf_q <= {hwdata[`CMD_WIDE_BIT], hwdata[`CMD_WRITE_BIT],
                hwdata[7:0]};
            rdata_q <= hwdata[`CMD_WRITE_BIT] ? wdata_q : 16'h0000;
        end else if ((state_q == ST_RECV) & rise_pulse) begin
            rdata_q <= {rdata_q[14:0], data_s};
        end
    end

    // Line is released outside the command frame and whenever disabled
    assign link_data_oe_n = ~((state_q == ST_SEND) & link_enable);
    assign link_data_o = shift_q[26];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_disabled_gpio: assert property (@(posedge hclk) disable iff (!hresetn)
        !link_enable |-> link_gpio_sel && !core_clock_on && link_data_oe_n)
        else $error("disabled initiator still owns the link");

    a_enable_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        link_enable |=> link_enable)
        else $error("link enable was cleared without reset");

    a_park_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (park && !link_clock_out) |=> !link_clock_out)
        else $error("link clock rose while parked");

    a_high_finish: assert property (@(posedge hclk) disable iff (!hresetn)
        (park && link_clock_out && link_enable) |-> ##[1:16] !link_clock_out)
        else $error("high phase did not finish while parking");

    a_wait_runs: assert property (@(posedge hclk) disable iff (!hresetn)
        (cpu_wait && !cpu_stop && !stop_in_wait && link_enable)
        |-> core_clock_on)
        else $error("wait halted core with stop-in-wait clear");

    a_pending_done: assert property (@(posedge hclk) disable iff (!hresetn)
        (stop_req && !idle) |-> core_clock_on)
        else $error("clocks halted with a transfer pending");

    a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        target_irq_signal |-> link_irq_enable && irq_s)
        else $error("target interrupt raised while disabled");

    a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(target_irq_in) ##1 (link_irq_enable && target_irq_in) [*3]
        |-> target_irq_signal)
        else $error("target interrupt not passed on");

    a_err_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_st0 && hwdata[`ST0_ERROR] && !ack_timeout && !stat_err
         && !start_idle) |=> !link_error_irq && stat0_q == 8'h00)
        else $error("error flags survived the clear");

    a_timeout_flags: assert property (@(posedge hclk) disable iff (!hresetn)
        ack_timeout |=> stat0_q[`ST0_ERROR] && stat0_q[`ST0_TIMEOUT]
        && state_q == ST_IDLE)
        else $error("timeout did not set both flags");

    a_frozen_buf: assert property (@(posedge hclk) disable iff (!hresetn)
        (start && error_summary_flag) |=> $stable(addr_buf_q)
        && shift_q[26:25] == `CODE_IDLE)
        else $error("transfer not replaced by idle command");
endmodule // die_link_initiator

// >>> die_link_pkg.sv
// Types shared by the link initiator
package die_link_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SEND = 5'b00010,
        ST_ACK = 5'b00100,
        ST_STAT = 5'b01000,
        ST_RECV = 5'b10000
    } xfer_state_t;
endpackage

// >>> link_clock_gen.sv
// Divider that makes the link clock and its edge pulses
`timescale 1ns/100ps
module link_clock_gen (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic [3:0] div,
    output logic link_clock_out,
    output logic rise_pulse,
    output logic fall_pulse
);
    logic [3:0] cnt_q;
    logic active;
    logic wrap;

    // A high phase always runs to its end, so the clock parks low
    assign active = run | link_clock_out;
    assign wrap = active && (cnt_q == div);
    assign rise_pulse = wrap & ~link_clock_out;
    assign fall_pulse = wrap & link_clock_out;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 4'h0;
            link_clock_out <= 1'b0;
        end else if (wrap) begin
            cnt_q <= 4'h0;
            link_clock_out <= ~link_clock_out;
        end else if (active) begin
            cnt_q <= cnt_q + 4'h1;
        end else begin
            cnt_q <= 4'h0;
        end
    end
endmodule // link_clock_gen

// >>> link_sync2.sv
// Two-flop synchroniser for the two link inputs
`timescale 1ns/100ps
module link_sync2 (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] async_in,
    output logic [1:0] sync_out
);
    logic [1:0] meta_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= 2'h0;
            sync_out <= 2'h0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // link_sync2

// >>> link_target_model.sv
// Behavioural model of the target die at the far end of the link
`timescale 1ns/100ps
module link_target_model (
    input wire logic hclk,
    input wire logic rst_n,
    input wire logic link_clock_out,
    input wire logic link_data_o,
    input wire logic link_data_oe_n,
    input wire logic mute,
    input wire logic [3:0] ack_dly,
    input wire logic err_bit,
    input wire logic [15:0] rd_val,
    input wire logic irq_raise,
    output logic link_data_i,
    output logic target_irq_in = 1'b0,
    output logic [26:0] frame_q,
    output logic [7:0] nfr_q = 8'h00
);
    logic [26:0] sh_q;
    logic rel_q = 1'b1;
    logic ans_q = 1'b0;
    logic bit_q = 1'b0;
    logic tog_q = 1'b0;
    logic lc_q = 1'b0;
    logic oe_q = 1'b1;
    logic do_q = 1'b0;
    logic irq_q = 1'b0;
    int nb = 0;
    logic q[$];
    // Released line toggles so a stale level is never mistaken for an answer
    assign link_data_i = rel_q ? tog_q : bit_q;
    always @(posedge hclk) tog_q <= ~tog_q;
    // Link edges are seen one hclk late, with the line as it stood before
    // the edge, so they never race the initiator's own updates
    always @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            nb = 0;
            q.delete();
            rel_q <= 1'b1;
            ans_q <= 1'b0;
            lc_q <= 1'b0;
            oe_q <= 1'b1;
        end else begin
            lc_q <= link_clock_out;
            oe_q <= link_data_oe_n;
            do_q <= link_data_o;
            irq_q <= irq_raise;
            if (irq_raise && !irq_q)
                target_irq_in <= 1'b1;
            if (link_clock_out && !lc_q && !oe_q) begin
                sh_q = {sh_q[25:0], do_q};
                nb++;
                if (nb == 27) begin
                    nb = 0;
                    frame_q <= sh_q;
                    nfr_q <= nfr_q + 8'h01;
                    rel_q <= 1'b0;
                    bit_q <= 1'b0;
                    // Write to 0x7e is the target's clearing sequence
                    if (sh_q[26:24] == 3'b100 && sh_q[23:16] == 8'h7e)
                        target_irq_in <= 1'b0;
                    // Silent target holds the line low until the next frame
                    if (!mute && sh_q[26:25] != 2'b00) begin
                        repeat (ack_dly) q.push_back(1'b0);
                        q.push_back(1'b1);
                        q.push_back(err_bit);
                        if (sh_q[26:25] == 2'b01)
                            for (int i = 15; i >= 0; i--)
                                q.push_back(rd_val[i]);
                        ans_q <= 1'b1;
                    end
                end
            end else if (!link_clock_out && lc_q && !rel_q) begin
                if (q.size() > 0) begin
                    bit_q <= q.pop_front();
                end else if (ans_q) begin
                    rel_q <= 1'b1;
                    ans_q <= 1'b0;
                end
            end
        end
    end
endmodule // link_target_model

// >>> tb_top.sv
// Self-checking bench for the die link initiator
`timescale 1ns/100ps
`include "die_link_cfg.svh"
module tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic cpu_wait = 1'b0, cpu_stop = 1'b0, mute = 1'b0, err_bit = 1'b0;
    logic irq_raise = 1'b0, hreadyout, hresp, link_clock_out, link_data_o;
    logic link_data_oe_n, link_data_i, target_irq_in, link_gpio_sel;
    logic core_clock_on, target_irq_signal, link_error_irq;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [3:0] ack_dly = 4'h0;
    logic [15:0] rd_val = 16'h0;
    logic [26:0] frame;
    logic [7:0] nfr, n0;
    int fail_count = 0, checked = 0;
    always #5 hclk = ~hclk;
    die_link_initiator dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .cpu_wait(cpu_wait),
        .cpu_stop(cpu_stop), .link_clock_out(link_clock_out),
        .link_data_o(link_data_o), .link_data_oe_n(link_data_oe_n),
        .link_data_i(link_data_i), .target_irq_in(target_irq_in),
        .link_gpio_sel(link_gpio_sel), .core_clock_on(core_clock_on),
        .target_irq_signal(target_irq_signal),
        .link_error_irq(link_error_irq));
    link_target_model tgt_u (.hclk(hclk), .rst_n(hresetn),
        .link_clock_out(link_clock_out), .link_data_o(link_data_o),
        .link_data_oe_n(link_data_oe_n), .mute(mute), .ack_dly(ack_dly),
        .err_bit(err_bit), .rd_val(rd_val), .irq_raise(irq_raise),
        .link_data_i(link_data_i), .target_irq_in(target_irq_in),
        .frame_q(frame), .nfr_q(nfr));
    task automatic wrap_up();
        $display("mismatches %0d, checks %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic hang();
        fail_count++;
        $display("[ERR] %0t wait limit", $time);
        wrap_up();
    endtask
    task automatic chk(input logic [31:0] g, e, input string m);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t %s got %h", $time, m, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic hw();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 3000);
        if (n >= 3000) hang();
    endtask
    // One single word transfer; read data lands in r
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        hw();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        hw();
        r = hrdata;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        bus(1, `OFS_WDATA, {16'h0, d});
        bus(1, `OFS_COMMAND, {23'h0, w, a});
        n = 0;
        do begin
            bus(0, `OFS_STATUS_1, 0);
            n++;
        end while (r[0] !== 1'b0 && n < 300);
        if (n >= 300) hang();
    endtask
    task automatic s_init();
        chk(link_gpio_sel, 1, "gpio");
        chk(core_clock_on, 0, "clk off");
        bus(0, `OFS_CONTROL_0, 0);
        chk(r, 0, "ctl reset");
        bus(1, `OFS_CONTROL_0, 32'h0834);
        bus(0, `OFS_CONTROL_0, 0);
        chk(r, 32'h0834, "ctl rw");
        n0 = nfr;
        xfer(1, 8'h01, 16'h0);
        chk(nfr, n0, "frame while off");
        bus(1, `OFS_CONTROL_0, 32'h0835);
        cyc(1);
        chk(link_gpio_sel, 0, "gpio on");
        bus(1, `OFS_CONTROL_0, 32'h0834);
        bus(0, `OFS_CONTROL_0, 0);
        chk(r, 32'h0835, "write once");
    endtask
    task automatic s_park(input logic stop);
        int n;
        if (!stop) begin
            cpu_wait <= 1'b1;
            xfer(1, 8'h21, 16'h0f0f);
            chk(frame, {11'h421, 16'h0f0f}, "wait run");
            chk(core_clock_on, 1, "wait clk");
            cpu_wait <= 1'b0;
        end
        bus(1, `OFS_CONTROL_0, stop ? 32'h0835 : 32'h0837);
        n0 = nfr;
        bus(1, `OFS_COMMAND, 32'h0000013c);
        if (stop) cpu_stop <= 1'b1;
        else cpu_wait <= 1'b1;
        n = 0;
        while (core_clock_on !== 1'b0 && n < 3000) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 3000) hang();
        chk(nfr, n0 + 8'h01, "finish first");
        cyc(30);
        chk(link_clock_out, 0, "parked low");
        cpu_stop <= 1'b0;
        cpu_wait <= 1'b0;
        ack_dly <= 4'h3;
        rd_val <= stop ? 16'h5a96 : 16'h96a5;
        xfer(0, 8'h11, 16'h0);
        bus(0, `OFS_RDATA, 0);
        chk(r, stop ? 32'h5a96 : 32'h96a5, "read after wake");
        bus(0, `OFS_CONTROL_0, 0);
        chk(r, stop ? 32'h0835 : 32'h0837, "ctl kept");
    endtask
    task automatic s_irq();
        irq_raise <= 1'b1;
        cyc(5);
        chk(target_irq_signal, 1, "irq on");
        bus(1, `OFS_CONTROL_0, 32'h0831);
        cyc(1);
        chk(target_irq_signal, 0, "masked");
        bus(0, `OFS_STATUS_1, 0);
        chk(r[7], 1, "pin level");
        bus(1, `OFS_CONTROL_0, 32'h0835);
        xfer(1, 8'h3c, 16'h0001);
        cpu_stop <= 1'b1;
        cyc(3);
        chk(target_irq_signal, 1, "in stop");
        cpu_stop <= 1'b0;
        irq_raise <= 1'b0;
        xfer(1, 8'h7e, 16'h0);
        cyc(4);
        chk(target_irq_signal, 0, "cleared");
    endtask
    task automatic s_err();
        bus(1, `OFS_CONTROL_0, 32'h0831);
        mute <= 1'b1;
        xfer(1, 8'h22, 16'h1234);
        bus(0, `OFS_STATUS_0, 0);
        chk(r, 32'h81, "timeout");
        chk(link_error_irq, 1, "err irq");
        mute <= 1'b0;
        n0 = nfr;
        xfer(1, 8'h33, 16'h5555);
        chk(frame[26:25], 0, "idle code");
        bus(0, `OFS_ADDR_BUF, 0);
        chk(r, 32'h122, "frozen");
        bus(0, `OFS_STATUS_0, 0);
        chk(r, 32'h85, "cancel");
        bus(1, `OFS_STATUS_0, 32'h80);
        bus(0, `OFS_STATUS_0, 0);
        chk(r, 0, "all clear");
        err_bit <= 1'b1;
        xfer(1, 8'h44, 16'h0);
        bus(0, `OFS_STATUS_0, 0);
        chk(r, 32'h82, "target err");
        err_bit <= 1'b0;
        bus(1, `OFS_STATUS_0, 32'h80);
        cyc(1);
        chk(link_error_irq, 0, "irq drop");
    endtask
    task automatic s_reset();
        bus(1, `OFS_COMMAND, 32'h000001ff);
        cyc(40);
        hresetn <= 1'b0;
        cyc(1);
        chk(link_clock_out, 0, "clk abort");
        chk(link_data_oe_n, 1, "line free");
        chk(link_gpio_sel, 1, "gpio back");
        hresetn <= 1'b1;
        bus(0, `OFS_CONTROL_0, 0);
        chk(r, 0, "disabled");
    endtask
    initial begin
        #900000;
        hang();
    end
    initial begin
        cyc(16);
        hresetn <= 1'b1;
        s_init();
        s_park(1'b0);
        s_park(1'b1);
        s_irq();
        s_err();
        s_reset();
        wrap_up();
    end
endmodule // tb_top
